// >>> rtl/ccl_device.sv
// Control and status registers and line I/O of a four-channel codec.
// Contract
// - enable/mode register written 4A, read 4B.
// - four channel enables gate commands, reset 0F.
// - host writes reserved bits zero; readback undefined.
// - robbed-bit enable acts only under mu-law.
// - idle output: resistor to reference or high-Z.
// - legacy power bit stored, no effect.
// - real-time read 4D keeps, 4F clears interrupt.
// - two real-time bits per channel, channel one low.
// - real-time read ignores channel enables.
// - gains register 50/51, three gain bits.
// - five-bit scaling field, resets to zero.
// - scaling 10000 loopback, zero means cutoff.
// - pin data latched, driven only on outputs.
// - muxed second output needs E1 multiplex mode.
// - bits 7 and 6 drive output-only pins.
// - direction register 54/55, five pins, reset input.
// - bit 6 read-only channel active flag.
// - bit 5 read-only global frame-sync-lost flag; read 55 returns 00 while no channel is enabled.
// - activate command sets enabled channels active.
// - masked real-time changes never raise interrupt.
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "ccl_map.svh"

module ccl_device (
	// Clock and reset
	input wire logic CORE_CLK,
	input wire logic SRST,
	// Command link
	ccl_link_if.dev LINK,
	// Debounced line inputs and their change masks
	input wire logic [7:0] RT_IN,
	input wire logic [7:0] RT_MASK,
	// Global chip state
	input wire logic MU_LAW_SEL,
	input wire logic E1_MUX_EN,
	input wire logic FRAME_SYNC_LOST,
	// Line signal pins, five per channel
	output logic [19:0] LINE_OUT,
	output logic [19:0] LINE_OE_N,
	output logic [3:0] MUX_LINE_OUT,
	output logic [7:0] EXTRA_OUT,
	// Channel and analog control
	output logic [3:0] CHAN_ACTIVE,
	output logic [3:0] VOICE_OUTPUT_PIN_HIZ,
	output logic [3:0] VOICE_OUTPUT_PIN_REF,
	output logic ROBBED_BIT_EN,
	output logic [31:0] GAIN_CFG,
	output logic [3:0] LOOPBACK,
	output logic [3:0] SCALE_CUTOFF
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------

	// Lowest enabled channel supplies the data of channel reads.
	function automatic ccl_pkg::ccl_chan_t first_chan(input logic [3:0] m);
		ccl_pkg::ccl_chan_t r;
		r = 2'h0;
		for (int i = 3; i >= 0; i--) begin
			if (m[i]) begin
				r = 2'(i);
			end
		end
		return r;
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [7:0] enmode_q;
	logic [31:0] gain_q;
	logic [31:0] pind_q;
	logic [19:0] dir_q;
	logic [3:0] active_q;
	logic frame_sync_lost_flag_q;
	logic [7:0] rt_prev_q;
	logic rt_seen_q;
	logic irq_q;

	// ----------------------------------------
	// Command decode
	// ----------------------------------------
	// direction from bit zero.
	wire is_wr = LINK.strobe & ~LINK.cmd[`CCL_RW_BIT];
	wire is_rd = LINK.strobe & LINK.cmd[`CCL_RW_BIT];
	wire [7:0] op = LINK.cmd & 8'hFE;
	wire wr_enmode = is_wr && op == `CCL_CMD_ENMODE;
	wire wr_gain = is_wr && op == `CCL_CMD_GAIN;
	wire wr_pind = is_wr && op == `CCL_CMD_PIND;
	wire wr_dir = is_wr && op == `CCL_CMD_DIR;
	wire do_act = is_wr && LINK.cmd == `CCL_CMD_ACTIVATE;
	wire rd_rt = is_rd && (LINK.cmd & 8'hFD) == `CCL_CMD_RT;
	wire rt_clr = rd_rt & LINK.cmd[`CCL_RT_CLR_BIT];

	wire [3:0] chan_en = enmode_q[3:0];
	wire sel_ok = |chan_en;
	wire ccl_pkg::ccl_chan_t sel = first_chan(chan_en);
	wire [7:0] sel_gain = gain_q[8*sel+:8];
	wire [7:0] sel_pind = pind_q[8*sel+:8];
	wire [4:0] sel_dir = dir_q[5*sel+:5];

	wire sel_act = sel_ok & active_q[sel];
	wire [7:0] dir_rd = {1'b0, sel_act, frame_sync_lost_flag_q, sel_ok ? sel_dir : 5'h00};

	wire [7:0] rt_byte = RT_IN;
	wire [7:0] rd_mux =
		rd_rt ? rt_byte :
		op == `CCL_CMD_ENMODE ? (enmode_q & `CCL_ENMODE_WMASK) :
		!sel_ok ? 8'h00 :
		op == `CCL_CMD_GAIN ? sel_gain :
		op == `CCL_CMD_PIND ? sel_pind :
		op == `CCL_CMD_DIR ? dir_rd : 8'h00;

	wire [7:0] enmode_wr = LINK.wdat & `CCL_ENMODE_WMASK;

	wire [7:0] rt_chg = (RT_IN ^ rt_prev_q) & ~RT_MASK;
	wire irq_set = rt_seen_q & (|rt_chg);
	wire irq_d = irq_set | (irq_q & ~rt_clr);

	// ----------------------------------------
	// Global register and interrupt
	// ----------------------------------------
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			enmode_q <= `CCL_ENMODE_RST;
			frame_sync_lost_flag_q <= 1'b0;
			rt_prev_q <= 8'h00;
			rt_seen_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			if (wr_enmode) begin
				enmode_q <= enmode_wr;
			end
			frame_sync_lost_flag_q <= FRAME_SYNC_LOST;
			rt_prev_q <= RT_IN;
			rt_seen_q <= 1'b1;
			irq_q <= irq_d;
		end
	end

	// ----------------------------------------
	// Per-channel registers
	// ----------------------------------------
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			gain_q <= {4{`CCL_GAIN_RST}};
			pind_q <= {4{`CCL_PIND_RST}};
			dir_q <= {4{`CCL_DIR_RST}};
			active_q <= 4'h0;
		end else begin
			for (int c = 0; c < 4; c++) begin
				if (chan_en[c]) begin
					if (wr_gain) begin
						gain_q[8*c+:8] <= LINK.wdat;
					end
					if (wr_pind) begin
						pind_q[8*c+:8] <= LINK.wdat;
					end
					if (wr_dir) begin
						dir_q[5*c+:5] <= LINK.wdat[4:0];
					end
					if (do_act) begin
						active_q[c] <= 1'b1;
					end
				end
			end
		end
	end

	// ----------------------------------------
	// Link answer
	// ----------------------------------------
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			LINK.rvld <= 1'b0;
			LINK.rdat <= 8'h00;
			LINK.irq_n <= 1'b1;
		end else begin
			LINK.rvld <= is_rd;
			if (is_rd) begin
				LINK.rdat <= rd_mux;
			end
			LINK.irq_n <= ~irq_d;
		end
	end

	// ----------------------------------------
	// Registered pin and control outputs
	// ----------------------------------------
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			LINE_OUT <= 20'h00000;
			LINE_OE_N <= 20'hFFFFF;
			MUX_LINE_OUT <= 4'h0;
			EXTRA_OUT <= 8'h00;
			CHAN_ACTIVE <= 4'h0;
			VOICE_OUTPUT_PIN_HIZ <= 4'h0;
			VOICE_OUTPUT_PIN_REF <= 4'hF;
			ROBBED_BIT_EN <= 1'b0;
			GAIN_CFG <= 32'h00000000;
			LOOPBACK <= 4'h0;
			SCALE_CUTOFF <= 4'hF;
		end else begin
			for (int c = 0; c < 4; c++) begin
				LINE_OUT[5*c+:5] <= pind_q[8*c+:5] & dir_q[5*c+:5];
				LINE_OE_N[5*c+:5] <= ~dir_q[5*c+:5];
				MUX_LINE_OUT[c] <= E1_MUX_EN & pind_q[8*c+`CCL_MUXOUT_BIT];
				EXTRA_OUT[2*c+:2] <= pind_q[8*c+6+:2];
				VOICE_OUTPUT_PIN_HIZ[c] <= ~active_q[c] & enmode_q[`CCL_IDLE_BIT];
				VOICE_OUTPUT_PIN_REF[c] <= ~active_q[c] & ~enmode_q[`CCL_IDLE_BIT];
				LOOPBACK[c] <= gain_q[8*c+:5] == `CCL_SCALE_FDL;
				SCALE_CUTOFF[c] <= gain_q[8*c+:5] == `CCL_SCALE_CUT;
			end
			CHAN_ACTIVE <= active_q;
			ROBBED_BIT_EN <= enmode_q[`CCL_RBE_BIT] & MU_LAW_SEL;
			GAIN_CFG <= gain_q;
		end
	end

endmodule

// >>> rtl/ccl_host.sv
// Host controller that issues link commands ordered over Avalon-MM.
`timescale 1ns/1ps
`include "ccl_map.svh"

module ccl_host (
	// Clock and reset
	input wire logic CORE_CLK,
	input wire logic SRST,
	// Avalon-MM slave
	input wire logic [1:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	// Command link
	ccl_link_if.hst LINK
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	ccl_pkg::ccl_hstate_t state_q;
	ccl_pkg::ccl_byte_t rd_q;
	logic irq_s1_q;
	logic irq_s2_q;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	wire cmd_wr = AVS_WRITE && AVS_ADDRESS == `CCL_AV_CMD;
	wire busy = state_q != ccl_pkg::CCL_IDLE;
	wire can_go = ~cmd_wr | ~busy;
	wire accept = (AVS_READ | AVS_WRITE) & AVS_WAITREQUEST & can_go;
	wire [31:0] status = {22'h000000, ~irq_s2_q, busy, rd_q};
	wire [31:0] rd_mux = AVS_ADDRESS == `CCL_AV_STATUS ? status : 32'h00000000;

	// ----------------------------------------
	// Bus answer
	// ----------------------------------------
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			AVS_WAITREQUEST <= 1'b1;
			AVS_READDATA <= 32'h00000000;
		end else begin
			AVS_WAITREQUEST <= ~accept;
			if (accept && AVS_READ) begin
				AVS_READDATA <= rd_mux;
			end
		end
	end

	// ----------------------------------------
	// Link sequencer
	// ----------------------------------------
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			state_q <= ccl_pkg::CCL_IDLE;
			LINK.strobe <= 1'b0;
			LINK.cmd <= 8'h00;
			LINK.wdat <= 8'h00;
			rd_q <= 8'h00;
		end else begin
			unique case (state_q)
				ccl_pkg::CCL_IDLE: begin
					if (accept && cmd_wr) begin
						LINK.strobe <= 1'b1;
						LINK.cmd <= AVS_WRITEDATA[7:0];
						LINK.wdat <= AVS_WRITEDATA[15:8];
						state_q <= ccl_pkg::CCL_ISSUE;
					end
				end
				ccl_pkg::CCL_ISSUE: begin
					LINK.strobe <= 1'b0;
					if (LINK.cmd[`CCL_RW_BIT]) begin
						state_q <= ccl_pkg::CCL_WAITR;
					end else begin
						state_q <= ccl_pkg::CCL_IDLE;
					end
				end
				ccl_pkg::CCL_WAITR: begin
					if (LINK.rvld) begin
						rd_q <= LINK.rdat;
						state_q <= ccl_pkg::CCL_IDLE;
					end
				end
				default: begin
					state_q <= ccl_pkg::CCL_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Interrupt line synchroniser
	// ----------------------------------------
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			irq_s1_q <= 1'b1;
			irq_s2_q <= 1'b1;
		end else begin
			irq_s1_q <= LINK.irq_n;
			irq_s2_q <= irq_s1_q;
		end
	end

endmodule

// >>> rtl/ccl_link_if.sv
// Command link between the host controller and the codec control block.
`timescale 1ns/1ps
interface ccl_link_if;
	logic strobe;
	ccl_pkg::ccl_byte_t cmd;
	ccl_pkg::ccl_byte_t wdat;
	ccl_pkg::ccl_byte_t rdat;
	logic rvld;
	logic irq_n;

	modport dev (
		input strobe,
		input cmd,
		input wdat,
		output rdat,
		output rvld,
		output irq_n
	);

	modport hst (
		output strobe,
		output cmd,
		output wdat,
		input rdat,
		input rvld,
		input irq_n
	);
endinterface

// >>> rtl/ccl_map.svh
// Command codes, field positions, reset values and register offsets.
`ifndef CCL_MAP_SVH
`define CCL_MAP_SVH

// ----------------------------------------
// Link command codes
// ----------------------------------------
`define CCL_CMD_ACTIVATE 8'h0E
`define CCL_CMD_ENMODE 8'h4A
`define CCL_CMD_RT 8'h4D
`define CCL_CMD_GAIN 8'h50
`define CCL_CMD_PIND 8'h52
`define CCL_CMD_DIR 8'h54
`define CCL_RW_BIT 0
`define CCL_RT_CLR_BIT 1

// ----------------------------------------
// Field positions and codes
// ----------------------------------------
`define CCL_RBE_BIT 6
`define CCL_IDLE_BIT 5
`define CCL_LPM_BIT 4
`define CCL_ENMODE_WMASK 8'h7F
`define CCL_SCALE_FDL 5'h10
`define CCL_SCALE_CUT 5'h00
`define CCL_MUXOUT_BIT 5
`define CCL_CHANNEL_ACTIVE_FLAG_BIT 6
`define CCL_FRAME_SYNC_LOST_FLAG_BIT 5
`define CCL_DIR_W 5

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CCL_ENMODE_RST 8'h0F
`define CCL_GAIN_RST 8'h00
`define CCL_PIND_RST 8'h00
`define CCL_DIR_RST 5'h00

// ----------------------------------------
// Host register offsets (word index)
// ----------------------------------------
`define CCL_AV_CMD 2'h0
`define CCL_AV_STATUS 2'h1
`define CCL_ST_BUSY_BIT 8
`define CCL_ST_IRQ_BIT 9

`endif

// >>> rtl/ccl_pkg.sv
// Shared types of the channel control link.
package ccl_pkg;
	typedef logic [7:0] ccl_byte_t;
	typedef logic [1:0] ccl_chan_t;
	typedef enum logic [2:0] {
		CCL_IDLE = 3'b001,
		CCL_ISSUE = 3'b010,
		CCL_WAITR = 3'b100
	} ccl_hstate_t;
endpackage

// >>> tb/ccl_properties.sv
// Assertions on the command link between host controller and codec block.
`timescale 1ns/1ps
module ccl_properties (
	// Clock and reset
	input logic CORE_CLK,
	input logic SRST,
	// Link signals
	input logic strobe,
	input ccl_pkg::ccl_byte_t cmd,
	input ccl_pkg::ccl_byte_t wdat,
	input ccl_pkg::ccl_byte_t rdat,
	input logic rvld,
	input logic irq_n
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (SRST);
	logic [7:0] en_q;
	wire rd = strobe && cmd[0];
	wire en_wr = strobe && cmd == 8'h4A;
	// Shadow of the enable register; the reserved bit is dropped.
	always_ff @(posedge CORE_CLK) begin
		if (SRST)
			en_q <= 8'h0F;
		else if (en_wr)
			en_q <= wdat & 8'h7F;
	end
	property p_rd_ans;
		rd |=> rvld;
	endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read unanswered");
	property p_rvld_cause;
		rvld |-> $past(rd);
	endproperty
	a_rvld_cause: assert property (p_rvld_cause) else $error("stray answer");
	property p_rvld_pulse;
		rvld |=> !rvld;
	endproperty
	a_rvld_pulse: assert property (p_rvld_pulse) else $error("long answer");
	property p_rdat_hold;
		!rvld |-> $stable(rdat);
	endproperty
	a_rdat_hold: assert property (p_rdat_hold) else $error("read data moved");
	property p_irq_clr;
		$rose(irq_n) |-> $past(strobe && cmd == 8'h4F) || $past(strobe && cmd == 8'h4F, 2);
	endproperty
	a_irq_clr: assert property (p_irq_clr) else $error("interrupt dropped");
	property p_irq_keep;
		strobe && cmd == 8'h4D && !irq_n |=> !irq_n ##1 !irq_n;
	endproperty
	a_irq_keep: assert property (p_irq_keep) else $error("interrupt lost");
	property p_en_read;
		strobe && cmd == 8'h4B |=> rdat == en_q;
	endproperty
	a_en_read: assert property (p_en_read) else $error("enable readback");
	property p_dis_read;
		strobe && (cmd == 8'h51 || cmd == 8'h53) && en_q[3:0] == 4'h0 |=> rdat == 8'h00;
	endproperty
	a_dis_read: assert property (p_dis_read) else $error("disabled read");
endmodule

// >>> tb/channel_control_and_line_io_tb.sv
// Self-checking bench joining host controller and codec control block.
`timescale 1ns/1ps
module channel_control_and_line_io_tb;
	logic clk, srst, rd, wr, wreq, mu, e1, fsl;
	logic [1:0] adr;
	logic [31:0] wd, rdata, s;
	logic [7:0] rt, msk, en, act, g[4], p[4], dr[4];
	logic [7:0] rds[5] = '{8'h4B, 8'h51, 8'h53, 8'h55, 8'h4D};
	logic [7:0] cmds[5] = '{8'h4A, 8'h50, 8'h52, 8'h54, 8'h0E};
	wire [104:0] pins;
	int n_mismatch, tests_run;
	ccl_link_if link();
	ccl_host u_ccl_host (.CORE_CLK(clk), .SRST(srst), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
		.AVS_WRITEDATA(wd), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq), .LINK(link));
	ccl_device u_ccl_device (.CORE_CLK(clk), .SRST(srst), .LINK(link), .RT_IN(rt), .RT_MASK(msk),
		.MU_LAW_SEL(mu), .E1_MUX_EN(e1), .FRAME_SYNC_LOST(fsl), .LINE_OUT(pins[104:85]),
		.LINE_OE_N(pins[84:65]), .MUX_LINE_OUT(pins[64:61]), .EXTRA_OUT(pins[60:53]),
		.CHAN_ACTIVE(pins[52:49]), .VOICE_OUTPUT_PIN_HIZ(pins[48:45]), .VOICE_OUTPUT_PIN_REF(pins[44:41]),
		.ROBBED_BIT_EN(pins[40]), .GAIN_CFG(pins[39:8]), .LOOPBACK(pins[7:4]), .SCALE_CUTOFF(pins[3:0]));
	ccl_properties u_ccl_properties (.CORE_CLK(clk), .SRST(srst), .strobe(link.strobe), .cmd(link.cmd),
		.wdat(link.wdat), .rdat(link.rdat), .rvld(link.rvld), .irq_n(link.irq_n));
	task automatic final_report();
		if (n_mismatch == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(logic [104:0] got, logic [104:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic av(logic w, logic [1:0] a, logic [31:0] d, output logic [31:0] r);
		@(posedge clk);
		wr <= w;
		rd <= !w;
		adr <= a;
		wd <= d;
		do @(posedge clk);
		while (wreq !== 1'h0);
		r = rdata;
		wr <= 1'h0;
		rd <= 1'h0;
	endtask
	task automatic link_op(logic [7:0] c, logic [7:0] d, output logic [7:0] b);
		av(1'h1, 2'h0, {16'h0000, d, c}, s);
		do av(1'h0, 2'h1, 32'h0, s);
		while (s[8]);
		b = s[7:0];
	endtask
	function automatic logic [7:0] exp_rd(logic [7:0] c);
		int k;
		k = -1;
		for (int i = 3; i >= 0; i--)
			if (en[i]) k = i;
		case (c)
			8'h4B: return en;
			8'h4D: return rt;
			8'h51: return k < 0 ? 8'h00 : g[k];
			8'h53: return k < 0 ? 8'h00 : p[k];
			default: return k < 0 ? {2'h0, fsl, 5'h00} : {1'h0, act[k], fsl, dr[k][4:0]};
		endcase
	endfunction
	function automatic logic [104:0] exp_pins();
		logic [19:0] lo, oe;
		logic [3:0] mx, hz, rf, lb, ct;
		logic [7:0] ex;
		logic [31:0] gc;
		for (int c = 0; c < 4; c++) begin
			for (int i = 0; i < 5; i++) begin
				lo[5*c+i] = p[c][i] & dr[c][i];
				oe[5*c+i] = !dr[c][i];
			end
			mx[c] = p[c][5] & e1;
			ex[2*c+:2] = p[c][7:6];
			hz[c] = !act[c] & en[5];
			rf[c] = !act[c] & !en[5];
			gc[8*c+:8] = g[c];
			lb[c] = g[c][4:0] == 5'h10;
			ct[c] = g[c][4:0] == 5'h00;
		end
		return {lo, oe, mx, ex, act[3:0], hz, rf, en[6] & mu, gc, lb, ct};
	endfunction
	// Issues one command, updates the model, then reads back the enable and real-time registers and those of the lowest enabled channel.
	task automatic step(logic [7:0] c, logic [7:0] d);
		logic [7:0] b;
		link_op(c, d, b);
		if (c == 8'h4A)
			en = d & 8'h7F;
		for (int k = 0; k < 4; k++) begin
			if (en[k] && c == 8'h50) g[k] = d;
			if (en[k] && c == 8'h52) p[k] = d;
			if (en[k] && c == 8'h54) dr[k] = d & 8'h1F;
			if (en[k] && c == 8'h0E) act[k] = 1'h1;
		end
		foreach (rds[j]) begin
			link_op(rds[j], 8'h00, b);
			chk(b, exp_rd(rds[j]));
		end
		chk(pins, exp_pins());
	endtask
	initial begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end
	initial begin
		repeat (30000) @(posedge clk);
		n_mismatch++;
		$display("mismatch at %0t: timeout", $time);
		final_report();
	end
	initial begin
		logic [7:0] c, d, b;
		logic [31:0] r;
		{srst, rd, wr, adr, wd, rt, msk, mu, e1, fsl} = {1'h1, 44'h0, 8'hFF, 3'h0};
		{en, act} = {8'h0F, 8'h00};
		foreach (g[k])
			{g[k], p[k], dr[k]} = 24'h000000;
		void'($urandom(32'h7C0D51E6));
		repeat (12) @(posedge clk);
		srst <= 1'h0;
		av(1'h1, 2'h3, 32'hFFFFFFFF, r);
		av(1'h0, 2'h2, 32'h0, r);
		chk(r, 0);
		step(8'h4D, 8'h00);
		for (int i = 0; i < 24; i++) begin
			c = cmds[$urandom % 5];
			d = 8'($urandom);
			d = c == 8'h4A ? d & 8'h7F : c == 8'h54 ? d & 8'h1F : d;
			mu <= 1'($urandom);
			e1 <= 1'($urandom);
			fsl <= 1'($urandom);
			rt <= 8'($urandom);
			step(c, d);
		end
		step(8'h4A, 8'h00);
		step(8'h50, 8'h10);
		step(8'h4A, 8'h65);
		step(8'h50, 8'h10);
		step(8'h0E, 8'h00);
		chk(link.irq_n, 1'h1);
		msk <= 8'hFE;
		rt <= rt ^ 8'h01;
		repeat (4) @(posedge clk);
		chk(link.irq_n, 1'h0);
		step(8'h4D, 8'h00);
		chk(link.irq_n, 1'h0);
		av(1'h0, 2'h1, 32'h0, r);
		chk(r[9], 1'h1);
		link_op(8'h4F, 8'h00, b);
		chk(b, rt);
		repeat (3) @(posedge clk);
		chk(link.irq_n, 1'h1);
		final_report();
	end
endmodule
